// [hw/fmc_fan_control.sv]
// fan monitor control registers and three pwm channels on wishbone
//
// Notes on behaviour
// - manual mode, start set, lock and force clear: duty writes drive the pwm outputs.
// - lock set makes duty registers read-only.
// - duty is linear eight bits, 00h none, ffh 255 of 256 clocks high.
// - during fan spin-up the readback reports zero duty.
// - readback equals the duty driven on the pin, except during spin-up.
// - write holding register apart from readback copy taken at period start.
// - written duty appears on readback within one pwm period.
// - device and vendor identifier registers at 3dh and 3eh, read-only.
// - silicon version register at 3fh, read-only, writes ignored.
// - control register at 40h resets to 04h; start, lock, ready, force.
// - start enables control from programmed registers.
// - start clear uses defaults; programmed contents are kept.
// - start clear drives full duty, 255 high and 1 low.
// - lock set freezes parameters and itself until reset or main power good rises.
// - lock set also freezes the start bit.
// - main power good clears the lock bit.
// - force full duty drives every pwm to full, lock or not.
// - duty written outside manual or start clear is kept; readback ffh.
`timescale 1ns/1ps
`default_nettype none
`include "fmc_consts.svh"
module fmc_fan_control
   import fmc_pkg::*;
#(
   parameter logic [7:0] DEVICE_IDENTIFIER = 8'h11, // arbitrary value
   parameter logic [7:0] VENDOR_ID = 8'h22, // arbitrary value
   parameter logic [7:0] VERSION_ID = 8'h03, // arbitrary value
   parameter int PWM_DIV = `FMC_PWM_DIV
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // pins
   input wire logic main_power_good_i,
   output logic [2:0] pwm_o
);
   localparam int DIV_W = (PWM_DIV > 1) ? $clog2(PWM_DIV) : 1;

   logic pg_meta_reg;
   logic pg_sync_reg;
   logic pg_prev_reg;
   logic [DIV_W-1:0] div_reg;
   logic tick;
   logic [7:0] phase_reg;
   logic start_reg;
   logic lock_reg;
   logic force_reg;
   logic [2:0] manual_reg;
   logic [2:0] spin_reg;
   fmc_duty_t hold_reg [3];
   fmc_duty_t req_duty [3];
   fmc_duty_t readback_reg [3];
   logic wr;
   logic rd_hit;
   logic [7:0] wbyte;
   fmc_duty_t rd_data;
   fmc_run_e run_state;

   // write lands on the edge where the master sees ack
   assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
   assign wbyte = dat_i[7:0];
   assign run_state = start_reg ? FMC_ST_RUN : FMC_ST_DEFAULT;

   // maps an address to a duty channel index, 3 when not a duty address
   function automatic logic [1:0] duty_index(input logic [7:0] a);
      if (a == `FMC_OFF_DUTY0) begin
         return 2'd0;
      end else if (a == `FMC_OFF_DUTY1) begin
         return 2'd1;
      end else if (a == `FMC_OFF_DUTY2) begin
         return 2'd2;
      end else begin
         return 2'd3;
      end
   endfunction

   // power good pin synchroniser and edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pg_meta_reg <= 1'b0;
         pg_sync_reg <= 1'b0;
         pg_prev_reg <= 1'b0;
      end else begin
         pg_meta_reg <= main_power_good_i;
         pg_sync_reg <= pg_meta_reg;
         pg_prev_reg <= pg_sync_reg;
      end
   end

   // pwm clock enable divider
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_reg <= '0;
      end else if (div_reg == DIV_W'(PWM_DIV - 1)) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end
   assign tick = (div_reg == DIV_W'(PWM_DIV - 1));

   // shared pwm phase, 256 pwm clocks a period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_reg <= 8'h00;
      end else if (tick) begin
         phase_reg <= phase_reg + 8'h01;
      end
   end

   // start bit
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_reg <= 1'b0;
      end else if (wr && adr_i == `FMC_OFF_RUN_CTRL && !lock_reg) begin
         start_reg <= wbyte[`FMC_BIT_START];
      end
   end

   // lock bit, only reset or power good clears it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lock_reg <= 1'b0;
      end else if (pg_sync_reg && !pg_prev_reg) begin
         lock_reg <= 1'b0;
      end else if (wr && adr_i == `FMC_OFF_RUN_CTRL && wbyte[`FMC_BIT_LOCK]) begin
         lock_reg <= 1'b1;
      end
   end

   // force full duty bit, writable even when locked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         force_reg <= 1'b0;
      end else if (wr && adr_i == `FMC_OFF_RUN_CTRL) begin
         force_reg <= wbyte[`FMC_BIT_FORCE];
      end
   end

   // manual mode and spin-up flags, parameters frozen by lock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         manual_reg <= 3'b000;
         spin_reg <= 3'b000;
      end else if (wr && !lock_reg) begin
         if (adr_i == `FMC_OFF_MODE) begin
            manual_reg <= wbyte[2:0];
         end else if (adr_i == `FMC_OFF_SPIN) begin
            spin_reg <= wbyte[2:0];
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_ch
         // write-only holding register
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               hold_reg[g] <= `FMC_DUTY_FULL;
            end else if (wr && !lock_reg && duty_index(adr_i) == 2'(g)) begin
               hold_reg[g] <= wbyte;
            end
         end

         // duty request: defaults unless started in manual mode with force clear
         always_comb begin
            if (force_reg || run_state == FMC_ST_DEFAULT || !manual_reg[g]) begin
               req_duty[g] = `FMC_DUTY_FULL;
            end else begin
               req_duty[g] = hold_reg[g];
            end
         end

         fmc_pwm_channel u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .tick_i(tick),
            .phase_i(phase_reg),
            .duty_i(req_duty[g]),
            .pwm_o(pwm_o[g]),
            .active_o()
         );

         // read-only copy, updated at period start
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               readback_reg[g] <= `FMC_DUTY_FULL;
            end else if (tick && phase_reg == 8'h00) begin
               readback_reg[g] <= spin_reg[g] ? `FMC_DUTY_ZERO : req_duty[g];
            end
         end
      end
   endgenerate

   // read mux
   always_comb begin
      rd_hit = 1'b1;
      rd_data = 8'h00;
      if (duty_index(adr_i) != 2'd3) begin
         rd_data = readback_reg[duty_index(adr_i)];
      end else if (adr_i == `FMC_OFF_MODE) begin
         rd_data = {5'h00, manual_reg};
      end else if (adr_i == `FMC_OFF_SPIN) begin
         rd_data = {5'h00, spin_reg};
      end else if (adr_i == `FMC_OFF_DEVICE_IDENTIFIER) begin
         rd_data = DEVICE_IDENTIFIER;
      end else if (adr_i == `FMC_OFF_VENDOR_ID) begin
         rd_data = VENDOR_ID;
      end else if (adr_i == `FMC_OFF_VERSION) begin
         rd_data = VERSION_ID;
      end else if (adr_i == `FMC_OFF_RUN_CTRL) begin
         rd_data = {4'h0, force_reg, 1'b1, lock_reg, start_reg};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // wishbone answer, one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
         dat_o <= (rd_hit && !we_i) ? {24'h000000, rd_data} : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

// [hw/fmc_consts.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FMC_CONSTS_SVH
`define FMC_CONSTS_SVH
`define FMC_OFF_DUTY0 8'h30
`define FMC_OFF_DUTY1 8'h31
`define FMC_OFF_DUTY2 8'h32
`define FMC_OFF_MODE 8'h33
`define FMC_OFF_SPIN 8'h34
`define FMC_OFF_DEVICE_IDENTIFIER 8'h3d
`define FMC_OFF_VENDOR_ID 8'h3e
`define FMC_OFF_VERSION 8'h3f
`define FMC_OFF_RUN_CTRL 8'h40
`define FMC_RUN_CTRL_RESET 8'h04
`define FMC_BIT_START 0
`define FMC_BIT_LOCK 1
`define FMC_BIT_READY 2
`define FMC_BIT_FORCE 3
`define FMC_DUTY_ZERO 8'h00
`define FMC_DUTY_FULL 8'hff
`define FMC_CLK_HZ 100000000
`define FMC_PWM_HZ 25000
`define FMC_PWM_DIV ((`FMC_CLK_HZ + (`FMC_PWM_HZ * 256) - 1) / (`FMC_PWM_HZ * 256))
`endif

// [hw/fmc_pkg.sv]
// types shared by the fan monitor control block
package fmc_pkg;
   typedef logic [7:0] fmc_duty_t;
   typedef enum logic {FMC_ST_DEFAULT, FMC_ST_RUN} fmc_run_e;
endpackage

// [hw/fmc_pwm_channel.sv]
// one pwm channel: active duty latch and output pin
`timescale 1ns/1ps
`default_nettype none
module fmc_pwm_channel
   import fmc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // timing
   input wire logic tick_i,
   input wire logic [7:0] phase_i,
   // duty request
   input wire fmc_duty_t duty_i,
   // outputs
   output logic pwm_o,
   output fmc_duty_t active_o
);
   fmc_duty_t active_reg;

   // duty latched only at period start
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_reg <= 8'hff;
      end else if (tick_i && phase_i == 8'h00) begin
         active_reg <= duty_i;
      end
   end

   // high while phase below duty; ff gives 255 high, 1 low
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwm_o <= 1'b0;
      end else if (tick_i) begin
         pwm_o <= (phase_i < ((phase_i == 8'h00) ? duty_i : active_reg));
      end
   end

   assign active_o = active_reg;
endmodule
`default_nettype wire

// [tb/fmc_fan_control_assertions.sv]
// port-level assertions for the fan control block
`timescale 1ns/1ps
`default_nettype none
`include "fmc_consts.svh"
module fmc_fan_control_chk #(
   parameter logic [7:0] DEVICE_IDENTIFIER = 8'h11,
   parameter logic [7:0] VENDOR_ID = 8'h22,
   parameter logic [7:0] VERSION_ID = 8'h03,
   parameter int PWM_DIV = 16
) (
   // design ports
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic main_power_good_i,
   input wire logic [2:0] pwm_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic tk, rd, wc, run_reg, frc_reg;
   int full_cnt;
   assign tk = cyc_i & stb_i & !ack_o;
   assign rd = tk & !we_i;
   assign wc = cyc_i & stb_i & we_i & sel_i[0] & ack_o & (adr_i == `FMC_OFF_RUN_CTRL);
   // start ever requested, force as last written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= 1'b0;
         frc_reg <= 1'b0;
      end else if (wc) begin
         run_reg <= run_reg | dat_i[0];
         frc_reg <= dat_i[3];
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i || (run_reg && !frc_reg)) full_cnt <= 0;
      else if (full_cnt < 600 * PWM_DIV) full_cnt <= full_cnt + 1;
   end
   property p_ack_next; tk |=> ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after request");
   property p_ack_drop; ack_o |=> !ack_o; endproperty
   a_ack_drop: assert property (p_ack_drop) else $error("ack longer than one cycle");
   property p_dev; rd && adr_i == `FMC_OFF_DEVICE_IDENTIFIER |=> dat_o == {24'h0, DEVICE_IDENTIFIER}; endproperty
   a_dev: assert property (p_dev) else $error("device_identifier wrong");
   property p_ven; rd && adr_i == `FMC_OFF_VENDOR_ID |=> dat_o == {24'h0, VENDOR_ID}; endproperty
   a_ven: assert property (p_ven) else $error("vendor id wrong");
   property p_ver; rd && adr_i == `FMC_OFF_VERSION |=> dat_o == {24'h0, VERSION_ID}; endproperty
   a_ver: assert property (p_ver) else $error("version wrong");
   property p_rsv; rd && adr_i == `FMC_OFF_RUN_CTRL |=> dat_o[31:4] == 28'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_rdy; rd && adr_i == `FMC_OFF_RUN_CTRL |=> dat_o[2]; endproperty
   a_rdy: assert property (p_rdy) else $error("ready bit low");
   property p_dhi; rd && adr_i == `FMC_OFF_DUTY0 |=> dat_o[31:8] == 24'h0; endproperty
   a_dhi: assert property (p_dhi) else $error("duty upper bits set");
   property p_full; full_cnt >= 600 * PWM_DIV |-> (pwm_o | $past(pwm_o)) == 3'h7; endproperty
   a_full: assert property (p_full) else $error("pwm low two cycles at full");
   c_run: cover property (wc && dat_i[0]);
   c_full: cover property (full_cnt >= 600 * PWM_DIV && !pwm_o[0]);
   c_duty: cover property (rd && adr_i == `FMC_OFF_DUTY0);
endmodule
bind fmc_fan_control fmc_fan_control_chk #(.DEVICE_IDENTIFIER(DEVICE_IDENTIFIER), .VENDOR_ID(VENDOR_ID),
   .VERSION_ID(VERSION_ID), .PWM_DIV(PWM_DIV)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .main_power_good_i(main_power_good_i), .pwm_o(pwm_o));
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the fan control block
`timescale 1ns/1ps
`default_nettype none
`include "fmc_consts.svh"
module tb_top;
   localparam logic [7:0] DEV = 8'h6b; // arbitrary value
   localparam logic [7:0] VEN = 8'h4e; // arbitrary value
   localparam logic [7:0] VER = 8'h07; // arbitrary value
   logic clk_i, rst_i, cyc_i, stb_i, we_i, pg, ack_o;
   logic [7:0] adr_i;
   logic [3:0] sel_i;
   logic [31:0] dat_i, dat_o, rdat;
   logic [2:0] pwm_o, man, spin;
   logic [7:0] ids[8] = '{8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h30, 8'h31, 8'h32, 8'h50};
   logic [7:0] vals[4] = '{8'h00, 8'h40, 8'h80, 8'hff};
   int num_errors, total_checks, run, lck, frc;
   int duty[3];
   fmc_fan_control #(.DEVICE_IDENTIFIER(DEV), .VENDOR_ID(VEN), .VERSION_ID(VER), .PWM_DIV(1)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .main_power_good_i(pg), .pwm_o(pwm_o));
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] v);
      int n;
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, v};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      rdat = dat_o;
      {cyc_i, stb_i} <= 2'b00;
      if (ack_o !== 1'b1) begin
         num_errors++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      wb(1'b1, a, v);
      if (a == `FMC_OFF_RUN_CTRL) frc = v[3];
      if (lck != 0) return;
      if (a == `FMC_OFF_RUN_CTRL) {lck[0], run[0]} = v[1:0];
      if (a >= `FMC_OFF_DUTY0 && a <= `FMC_OFF_DUTY2) duty[a - 8'h30] = v;
      if (a == `FMC_OFF_MODE) man = v[2:0];
      if (a == `FMC_OFF_SPIN) spin = v[2:0];
   endtask
   function automatic logic [31:0] exp_rd(input logic [7:0] a);
      int i;
      i = int'(a) - 48;
      if (a == `FMC_OFF_DEVICE_IDENTIFIER) return {24'h0, DEV};
      if (a == `FMC_OFF_VENDOR_ID) return {24'h0, VEN};
      if (a == `FMC_OFF_VERSION) return {24'h0, VER};
      if (a == `FMC_OFF_RUN_CTRL) return {28'h0, frc[0], 1'b1, lck[0], run[0]};
      if (i < 0 || i > 2 || spin[i]) return 32'h0;
      if (run == 0 || !man[i] || frc != 0) return 32'hff;
      return 32'(duty[i]);
   endfunction
   task automatic rd(input logic [7:0] a);
      wb(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), exp_rd(a), rdat);
   endtask
   task automatic hc(input int ch, input logic [31:0] e);
      logic [31:0] c;
      c = 0;
      repeat (256) begin
         @(negedge clk_i);
         c += pwm_o[ch];
      end
      chk("pwm high count", e, c);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {rst_i, cyc_i, stb_i, we_i, pg, adr_i, sel_i, dat_i} = {5'b10000, 8'h0, 4'h1, 32'h0};
      duty = '{255, 255, 255};
      {man, spin} = 6'h0;
      void'($urandom(32'haf2914d5));
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ids[k]) rd(ids[k]);
      wr(`FMC_OFF_VERSION, 8'h00);
      rd(`FMC_OFF_VERSION);
      repeat (600) @(posedge clk_i);
      hc(0, 255);
      $display("test reset done");
      wr(`FMC_OFF_MODE, 8'h07);
      wr(`FMC_OFF_RUN_CTRL, 8'hf1);
      rd(`FMC_OFF_RUN_CTRL);
      foreach (vals[k]) begin
         wr(`FMC_OFF_DUTY0, vals[k]);
         wr(`FMC_OFF_DUTY1, 8'($urandom));
         repeat (300) @(posedge clk_i);
         rd(`FMC_OFF_DUTY0);
         rd(`FMC_OFF_DUTY1);
         hc(0, 32'(vals[k]));
         hc(1, 32'(duty[1]));
      end
      $display("test manual done");
      wr(`FMC_OFF_SPIN, 8'h01);
      repeat (300) @(posedge clk_i);
      rd(`FMC_OFF_DUTY0);
      wr(`FMC_OFF_SPIN, 8'h00);
      wr(`FMC_OFF_RUN_CTRL, 8'h09);
      repeat (600) @(posedge clk_i);
      rd(`FMC_OFF_DUTY1);
      hc(2, 255);
      $display("test force done");
      wr(`FMC_OFF_RUN_CTRL, 8'h03);
      wr(`FMC_OFF_DUTY0, 8'h12);
      wr(`FMC_OFF_RUN_CTRL, 8'h08);
      repeat (300) @(posedge clk_i);
      rd(`FMC_OFF_RUN_CTRL);
      wr(`FMC_OFF_RUN_CTRL, 8'h01);
      repeat (300) @(posedge clk_i);
      rd(`FMC_OFF_DUTY0);
      pg <= 1'b1;
      repeat (6) @(posedge clk_i);
      pg <= 1'b0;
      lck = 0;
      rd(`FMC_OFF_RUN_CTRL);
      $display("test lock done");
      wr(`FMC_OFF_RUN_CTRL, 8'h00);
      wr(`FMC_OFF_DUTY1, 8'h33);
      repeat (300) @(posedge clk_i);
      rd(`FMC_OFF_DUTY1);
      repeat (1250) @(posedge clk_i);
      wr(`FMC_OFF_RUN_CTRL, 8'h01);
      repeat (300) @(posedge clk_i);
      rd(`FMC_OFF_DUTY1);
      wr(`FMC_OFF_MODE, 8'h05);
      repeat (300) @(posedge clk_i);
      rd(`FMC_OFF_DUTY1);
      wr(`FMC_OFF_MODE, 8'h07);
      repeat (300) @(posedge clk_i);
      rd(`FMC_OFF_DUTY1);
      $display("test stop done");
      close_out();
   end
endmodule
`default_nettype wire
